//--- verilog/lrt_core.sv
// LRA/ERM resonance tracking control core with register port and drive scheduling
`timescale 1ns/100ps
`include "lrt_consts.svh"
module lrt_core
    import lrt_pkg::*;
#(
    parameter int STARTUP_CYCLES = `LRT_STARTUP_NS / `LRT_CLK_NS,
    parameter int HALF_TICK_CYCLES = (`LRT_OL_UNIT_NS / 2) / `LRT_CLK_NS,
    parameter int PWM_PERIOD = `LRT_CLK_HZ / `LRT_PWM_HZ
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic i_play,
    input wire logic i_brake,
    input wire logic [7:0] i_amplitude,
    input wire logic i_bemf_valid,
    input wire logic i_bemf_zero_cross,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output lrt_drive_s o_drive,
    output logic o_synced,
    output logic o_open_loop
);
    localparam int SUW = $clog2(STARTUP_CYCLES + 1);
    localparam int HTW = $clog2(HALF_TICK_CYCLES + 1);

    lrt_cfg_s cfg_r;
    lrt_mode_e mode_r, mode_nxt;
    logic [7:0] res_period_r;
    logic en_d_r;
    logic [SUW-1:0] su_cnt_r;
    logic [HTW-1:0] ht_cnt_r;
    logic ht_tick;
    logic [8:0] half_timer_r;
    logic [8:0] cyc_timer_r;
    logic [8:0] half_meas_r;
    logic half_idx_r;
    logic zc_armed_r;
    logic polarity_r;
    logic first_half_r;
    logic [2:0] fail_cnt_r;
    logic lra_drive;
    logic zc_ok;
    logic timeout;
    logic fail_over;
    logic [8:0] default_half;
    logic [8:0] limit_half;
    logic drive_on;
    logic drive_sign;
    logic [7:0] drive_level;

    // Register writes; 0x22 is read-only so writes there fall through
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cfg_r.actuator_type_select <= `LRT_RST_ACT_TYPE;
            cfg_r.fallback_enable <= `LRT_RST_FB_EN;
            cfg_r.sync_fail_cycle_limit <= `LRT_RST_FAIL_LIM;
            cfg_r.drive_span <= `LRT_RST_SPAN;
            cfg_r.zero_cross_window <= `LRT_RST_ZC_WIN;
            cfg_r.fixed_drive_period <= `LRT_RST_FIXED;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `LRT_ADDR_FB_CTRL: cfg_r.actuator_type_select <= i_reg_wdata[`LRT_BIT_ACT_TYPE];
                `LRT_ADDR_FALLBACK: begin
                    cfg_r.fallback_enable <= i_reg_wdata[`LRT_BIT_FB_EN];
                    cfg_r.sync_fail_cycle_limit <= i_reg_wdata[`LRT_POS_FAIL_LIM +: 2];
                end
                `LRT_ADDR_DRIVE_SPAN: cfg_r.drive_span <= i_reg_wdata[`LRT_POS_SPAN +: 5];
                `LRT_ADDR_ZC_WIN: cfg_r.zero_cross_window <= i_reg_wdata[`LRT_POS_ZC_WIN +: 2];
                `LRT_ADDR_FIXED_PER: cfg_r.fixed_drive_period <= i_reg_wdata[`LRT_POS_FIXED +: 7];
                default: ;
            endcase
        end
    end

    // Registered read data, one cycle after the address; unmapped reads zero
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
        end else begin
            case (i_reg_addr)
                `LRT_ADDR_FB_CTRL: o_reg_rdata <= {cfg_r.actuator_type_select, 7'h00};
                `LRT_ADDR_FALLBACK: o_reg_rdata <= {2'h0, cfg_r.fallback_enable, 1'h0,
                                                    cfg_r.sync_fail_cycle_limit, 2'h0};
                `LRT_ADDR_DRIVE_SPAN: o_reg_rdata <= {3'h0, cfg_r.drive_span};
                `LRT_ADDR_ZC_WIN: o_reg_rdata <= {6'h00, cfg_r.zero_cross_window};
                `LRT_ADDR_FIXED_PER: o_reg_rdata <= {1'h0, cfg_r.fixed_drive_period};
                `LRT_ADDR_RES_PER: o_reg_rdata <= res_period_r;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // Enable edge and startup delay before any drive leaves the stage
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            en_d_r <= 1'b0;
            su_cnt_r <= '0;
        end else begin
            en_d_r <= i_enable;
            if (mode_r == LRT_ST_STARTUP) begin
                su_cnt_r <= su_cnt_r + 1'b1;
            end else begin
                su_cnt_r <= '0;
            end
        end
    end

    // Half-unit time base: two ticks per 98.49 us unit
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || ht_tick) begin
            ht_cnt_r <= '0;
        end else begin
            ht_cnt_r <= ht_cnt_r + 1'b1;
        end
    end
    assign ht_tick = (ht_cnt_r == HTW'(HALF_TICK_CYCLES - 1));

    // Half-period limits for each drive mode, all in half-unit ticks
    assign default_half = ({3'h0, cfg_r.drive_span, 1'b0} > {6'h00, cfg_r.zero_cross_window, 1'b0}) ?
                          ({3'h0, cfg_r.drive_span, 1'b0} - {6'h00, cfg_r.zero_cross_window, 1'b0}) :
                          9'h001;
    always_comb begin
        limit_half = default_half;
        if (mode_r == LRT_ST_OPEN_LOOP) begin
            limit_half = {2'h0, cfg_r.fixed_drive_period};
        end else if (mode_r == LRT_ST_TRACK && half_meas_r != 9'h000) begin
            limit_half = half_meas_r + {6'h00, cfg_r.zero_cross_window, 1'b0};
        end
    end

    // Tracking only looks at back-EMF; calibration has no path into it
    assign lra_drive = cfg_r.actuator_type_select &&
                       (mode_r == LRT_ST_TRACK || mode_r == LRT_ST_FALLBACK || mode_r == LRT_ST_OPEN_LOOP);
    assign zc_ok = lra_drive && mode_r != LRT_ST_OPEN_LOOP && i_bemf_valid && i_bemf_zero_cross;
    // The tick that ends the half counts, so a limit of n gives exactly n ticks per half
    assign timeout = lra_drive && !zc_ok && ht_tick && ({1'b0, half_timer_r} + 10'h001 >= {1'b0, limit_half});
    assign fail_over = cfg_r.fallback_enable && (fail_cnt_r > {1'b0, cfg_r.sync_fail_cycle_limit});

    // Mode sequencing
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            LRT_ST_IDLE: if (i_enable && !en_d_r) mode_nxt = LRT_ST_STARTUP;
            LRT_ST_STARTUP: if (su_cnt_r == SUW'(STARTUP_CYCLES - 1)) mode_nxt = LRT_ST_STANDBY;
            LRT_ST_STANDBY: if (i_play) mode_nxt = LRT_ST_TRACK;
            LRT_ST_TRACK: begin
                if (fail_over) mode_nxt = LRT_ST_OPEN_LOOP;
                else if (cfg_r.actuator_type_select && !i_bemf_valid) mode_nxt = LRT_ST_FALLBACK;
            end
            LRT_ST_FALLBACK: begin
                if (fail_over) mode_nxt = LRT_ST_OPEN_LOOP;
                else if (i_bemf_valid) mode_nxt = LRT_ST_TRACK;
            end
            LRT_ST_OPEN_LOOP: ; // Stays open loop, no resync, until the waveform ends
            default: mode_nxt = LRT_ST_IDLE;
        endcase
        if (!i_enable) begin
            mode_nxt = LRT_ST_IDLE;
        end else if (!i_play && mode_r > LRT_ST_STANDBY) begin
            mode_nxt = LRT_ST_STANDBY;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            mode_r <= LRT_ST_IDLE;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Commutation: flip on a valid crossing, or on timeout when no crossing came
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || !lra_drive) begin
            polarity_r <= 1'b0;
            half_timer_r <= 9'h000;
            first_half_r <= 1'b1;
        end else if (zc_ok || timeout) begin
            polarity_r <= !polarity_r;
            half_timer_r <= 9'h000;
            first_half_r <= 1'b0;
        end else if (ht_tick && half_timer_r != `LRT_TIMER_MAX) begin
            half_timer_r <= half_timer_r + 9'h001;
        end
    end

    // Measurement: half period after the first crossing, full period every cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || !lra_drive) begin
            half_meas_r <= 9'h000;
            cyc_timer_r <= 9'h000;
            half_idx_r <= 1'b0;
            zc_armed_r <= 1'b0;
        end else if (zc_ok) begin
            zc_armed_r <= 1'b1;
            half_idx_r <= zc_armed_r ? !half_idx_r : 1'b0;
            if (zc_armed_r) begin
                half_meas_r <= half_timer_r;
            end
            cyc_timer_r <= (zc_armed_r && !half_idx_r) ? cyc_timer_r : 9'h000;
        end else if (timeout) begin
            zc_armed_r <= 1'b0; // Unsynced half spoils the cycle being timed
            half_idx_r <= 1'b0;
            cyc_timer_r <= 9'h000;
        end else if (ht_tick && cyc_timer_r != `LRT_TIMER_MAX) begin
            cyc_timer_r <= cyc_timer_r + 9'h001;
        end
    end

    // Period readout in 98.49 us units, loaded only when a full cycle closes
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            res_period_r <= 8'h00;
        end else if (zc_ok && zc_armed_r && half_idx_r) begin
            res_period_r <= cyc_timer_r[8:1];
        end
    end

    // Count of unsynchronised half cycles, cleared by any valid crossing
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || mode_r == LRT_ST_STANDBY || zc_ok) begin
            fail_cnt_r <= 3'h0;
        end else if (timeout && fail_cnt_r != `LRT_FAIL_MAX) begin
            fail_cnt_r <= fail_cnt_r + 3'h1;
        end
    end

    // Drive request: overdrive and braking only in closed loop or fallback
    always_comb begin
        drive_on = (mode_r == LRT_ST_TRACK || mode_r == LRT_ST_FALLBACK || mode_r == LRT_ST_OPEN_LOOP);
        drive_sign = cfg_r.actuator_type_select && polarity_r;
        drive_level = i_amplitude;
        if (mode_r == LRT_ST_OPEN_LOOP) begin
            drive_on = drive_on && !i_brake;
        end else if (drive_on && i_brake) begin
            drive_sign = !drive_sign;
            drive_level = `LRT_LEVEL_FULL;
        end else if (drive_on && (first_half_r || mode_r == LRT_ST_FALLBACK)) begin
            drive_level = `LRT_LEVEL_FULL;
        end
    end

    // Status flags for the host
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_synced <= 1'b0;
            o_open_loop <= 1'b0;
        end else begin
            o_synced <= (mode_r == LRT_ST_TRACK) && cfg_r.actuator_type_select && zc_armed_r;
            o_open_loop <= (mode_r == LRT_ST_OPEN_LOOP) || (mode_r == LRT_ST_FALLBACK);
        end
    end

    // Internal PWM carrier feeding the trinary bridge
    lrt_pwm #(
        .PERIOD(PWM_PERIOD)
    ) u_pwm (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_enable(drive_on),
        .i_sign(drive_sign),
        .i_level(drive_level),
        .o_drive(o_drive)
    );
endmodule // lrt_core

//--- pkg/lrt_consts.svh
// Constants for the LRA resonance tracking controller: offsets, fields, resets, timing
`ifndef LRT_CONSTS_SVH
`define LRT_CONSTS_SVH
`define LRT_CLK_HZ 10000000
`define LRT_CLK_NS 100
`define LRT_STARTUP_NS 1170000
`define LRT_PWM_HZ 20500
`define LRT_OL_UNIT_NS 98490
`define LRT_ADDR_FB_CTRL 8'h1a
`define LRT_ADDR_DRIVE_SPAN 8'h1b
`define LRT_ADDR_ZC_WIN 8'h1e
`define LRT_ADDR_FALLBACK 8'h1f
`define LRT_ADDR_FIXED_PER 8'h20
`define LRT_ADDR_RES_PER 8'h22
`define LRT_BIT_ACT_TYPE 7
`define LRT_BIT_FB_EN 5
`define LRT_POS_FAIL_LIM 2
`define LRT_POS_ZC_WIN 0
`define LRT_POS_SPAN 0
`define LRT_POS_FIXED 0
`define LRT_RST_ACT_TYPE 1'h0
`define LRT_RST_FB_EN 1'h0
`define LRT_RST_FAIL_LIM 2'h1
`define LRT_RST_SPAN 5'h13
`define LRT_RST_ZC_WIN 2'h1
`define LRT_RST_FIXED 7'h32
`define LRT_TIMER_MAX 9'h1ff
`define LRT_FAIL_MAX 3'h7
`define LRT_LEVEL_FULL 8'hff
`endif

//--- pkg/lrt_pkg.sv
// Types shared by the LRA resonance tracking controller files
package lrt_pkg;
    typedef enum logic [2:0] {
        LRT_ST_IDLE = 3'b000,
        LRT_ST_STARTUP = 3'b001,
        LRT_ST_STANDBY = 3'b010,
        LRT_ST_TRACK = 3'b011,
        LRT_ST_FALLBACK = 3'b100,
        LRT_ST_OPEN_LOOP = 3'b101
    } lrt_mode_e;

    typedef struct packed {
        logic actuator_type_select;
        logic fallback_enable;
        logic [1:0] sync_fail_cycle_limit;
        logic [4:0] drive_span;
        logic [1:0] zero_cross_window;
        logic [6:0] fixed_drive_period;
    } lrt_cfg_s;

    typedef struct packed {
        logic pos;
        logic neg;
    } lrt_drive_s;
endpackage

//--- verilog/lrt_pwm.sv
// Trinary PWM output stage driver: +1, 0 or -1 on the actuator bridge
`timescale 1ns/100ps
`include "lrt_consts.svh"
module lrt_pwm
    import lrt_pkg::*;
#(
    parameter int PERIOD = `LRT_CLK_HZ / `LRT_PWM_HZ
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic i_sign,
    input wire logic [7:0] i_level,
    output lrt_drive_s o_drive
);
    // One spare bit so a power-of-two period still fits its own width
    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    localparam logic [CW-1:0] PER_W = CW'(PERIOD);

    logic [CW-1:0] cnt_r;
    logic [CW+7:0] on_prod;
    logic on_now;

    // Period counter sets the carrier near 20.5 kHz
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || cnt_r == LAST) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Duty scales with level; zero state between pulses keeps the bridge quiet
    assign on_prod = i_level * PER_W;
    assign on_now = i_enable && (cnt_r < on_prod[CW+7:8]);

    // Three levels: one side high per sign, both low otherwise, never both high
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_drive <= '0;
        end else begin
            o_drive.pos <= on_now && !i_sign;
            o_drive.neg <= on_now && i_sign;
        end
    end
endmodule // lrt_pwm

//--- dv/lrt_core_assertions.sv
// Port-level checks on the resonance tracking core
`timescale 1ns/100ps
module lrt_core_assertions
    import lrt_pkg::*;
#(
    parameter int STARTUP_CYCLES = 11700,
    parameter int HALF_TICK_CYCLES = 492,
    parameter int PWM_PERIOD = 487
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic i_brake,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire lrt_drive_s o_drive,
    input wire logic o_synced,
    input wire logic o_open_loop
);
    logic lra_r;
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    // Shadow of the actuator type bit, since the ERM checks depend on it
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            lra_r <= 1'b0;
        end else if (i_reg_wr && i_reg_addr == 8'h1a) begin
            lra_r <= i_reg_wdata[7];
        end
    end
    chk_drive_trinary: assert property (!(o_drive.pos && o_drive.neg))
        else $error("bridge driven both ways");
    chk_startup_quiet: assert property ($rose(i_enable) |-> ##2 (o_drive == 2'b00) [*8])
        else $error("drive during startup");
    chk_disabled_idle: assert property (!i_enable [*3] |-> o_drive == 2'b00 && !o_synced && !o_open_loop)
        else $error("activity while disabled");
    chk_fixed_readback: assert property (i_reg_wr && i_reg_addr == 8'h20 ##1 i_reg_addr == 8'h20
        |=> o_reg_rdata == {1'b0, $past(i_reg_wdata[6:0], 2)})
        else $error("fixed period readback wrong");
    chk_unmapped_zero: assert property (i_reg_addr < 8'h1a |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_sync_excludes_ol: assert property (o_synced |-> !o_open_loop)
        else $error("synced and open loop together");
    chk_erm_never_sync: assert property (!lra_r [*2] |-> !o_synced)
        else $error("ERM reported synced");
    chk_erm_one_sign: assert property ((!lra_r && !i_brake) [*3] |-> !o_drive.neg)
        else $error("ERM driven negative");
    cov_synced: cover property (o_synced);
    cov_open_loop: cover property (o_open_loop && o_drive.neg);
    cov_brake_ol: cover property (i_brake && o_open_loop);
endmodule // lrt_core_assertions

bind lrt_core lrt_core_assertions #(
    .STARTUP_CYCLES(STARTUP_CYCLES), .HALF_TICK_CYCLES(HALF_TICK_CYCLES), .PWM_PERIOD(PWM_PERIOD)
) u_lrt_core_assertions (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_enable(i_enable), .i_brake(i_brake), .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_drive(o_drive),
    .o_synced(o_synced), .o_open_loop(o_open_loop)
);

//--- dv/lrt_actuator_model.sv
// Behavioural actuator: back-EMF valid level and zero-crossing pulses
`timescale 1ns/100ps
module lrt_actuator_model
    import lrt_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire lrt_drive_s i_drive,
    input wire logic i_valid_en,
    input wire logic [15:0] i_half_len,
    output logic o_bemf_valid,
    output logic o_zero_cross
);
    logic [15:0] cnt_r;
    logic moving_r;
    // The coil only swings once the bridge has pushed it
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            moving_r <= 1'b0;
        end else if (i_drive.pos || i_drive.neg) begin
            moving_r <= 1'b1;
        end
    end
    // Crossings keep coming while back-EMF is invalid, like a noisy coil would
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || i_half_len == 16'h0000 || !moving_r) begin
            cnt_r <= 16'h0000;
            o_zero_cross <= 1'b0;
        end else if (cnt_r + 16'h0001 >= i_half_len) begin
            cnt_r <= 16'h0000;
            o_zero_cross <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            o_zero_cross <= 1'b0;
        end
    end
    assign o_bemf_valid = i_valid_en && moving_r;
endmodule // lrt_actuator_model

//--- dv/lrt_core_bench.sv
// Self-checking bench for the resonance tracking core
`timescale 1ns/100ps
`include "lrt_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module lrt_core_bench
    import lrt_pkg::*;
;
    localparam int PWM = 16;
    localparam int HT = 4;
    localparam int DEF_HALF = (2 * `LRT_RST_SPAN - 2 * `LRT_RST_ZC_WIN) * HT;
    logic i_clk_sys, i_reset, i_enable, i_play, i_brake, i_reg_wr, valid_en, bemf_valid, zero_cross;
    logic o_synced, o_open_loop;
    logic [7:0] i_amplitude, i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [15:0] half_len;
    logic [15:0] rst_tab [7] = '{16'h1a00, 16'h1f04, 16'h1b13, 16'h1e01, 16'h2032, 16'h2200, 16'h0500};
    lrt_drive_s o_drive;
    int num_errors = 0;
    int n_tests = 0;
    lrt_core #(.STARTUP_CYCLES(20), .HALF_TICK_CYCLES(HT), .PWM_PERIOD(PWM)) u_lrt_core (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_enable(i_enable), .i_play(i_play), .i_brake(i_brake),
        .i_amplitude(i_amplitude), .i_bemf_valid(bemf_valid), .i_bemf_zero_cross(zero_cross), .i_reg_wr(i_reg_wr),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_drive(o_drive),
        .o_synced(o_synced), .o_open_loop(o_open_loop));
    lrt_actuator_model u_lrt_actuator_model (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_drive(o_drive),
        .i_valid_en(valid_en), .i_half_len(half_len), .o_bemf_valid(bemf_valid), .o_zero_cross(zero_cross));
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
    endtask
    task automatic reg_check(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk_sys);
        i_reg_addr = a;
        @(negedge i_clk_sys);
        `CHK(o_reg_rdata, e)
    endtask
    // Bounded wait on a status flag; the timeout itself is the mismatch
    task automatic wait_flag(input bit ol, input logic v, input int lim);
        for (int k = 0; k < lim; k++) begin
            @(negedge i_clk_sys);
            if ((ol ? o_open_loop : o_synced) === v) break;
        end
        `CHK((ol ? o_open_loop : o_synced), v)
    endtask
    // Cycles between two reversals onto the negative side give the full drive period
    task automatic check_period(input int per, input int tol);
        int t = 0;
        int seen = 0;
        logic last_neg = 1'b1;
        for (int k = 0; k < 4 * per && seen < 2; k++) begin
            @(negedge i_clk_sys);
            if (seen == 1) t++;
            if (o_drive.neg && !last_neg) seen++;
            if (o_drive.pos || o_drive.neg) last_neg = o_drive.neg;
        end
        `CHK((seen == 2 && t >= per - tol && t <= per + tol), 1'b1)
    endtask
    task automatic quiet(input int cycles);
        repeat (cycles) begin
            @(negedge i_clk_sys);
            `CHK(o_drive, 2'b00)
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    // Whole sequence needs well under 10000 cycles
    initial begin
        #3000000;
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        {i_reset, i_enable, i_play, i_brake, i_reg_wr, valid_en} = 6'b100001;
        {i_amplitude, i_reg_addr, i_reg_wdata, half_len} = '0;
        repeat (6) @(negedge i_clk_sys);
        i_reset = 1'b0;
        foreach (rst_tab[i])
            reg_check(rst_tab[i][15:8], rst_tab[i][7:0]);
        reg_write(8'h20, 8'hff);
        reg_check(8'h20, 8'h7f);
        reg_write(8'h22, 8'h55);
        reg_check(8'h22, 8'h00);
        reg_write(8'h20, 8'h08);
        reg_write(8'h1a, 8'h80);
        i_amplitude = 8'h80;
        half_len = 16'd42;
        i_enable = 1'b1;
        i_play = 1'b1;
        quiet(18);
        for (int k = 0; k < 3 * PWM; k++) begin
            @(negedge i_clk_sys);
            if (o_drive !== 2'b00) break;
        end
        `CHK((o_drive !== 2'b00), 1'b1)
        wait_flag(1'b0, 1'b1, 400);
        repeat (300) @(negedge i_clk_sys);
        reg_check(8'h22, 8'((2 * 42) / (2 * HT)));
        half_len = 16'd46;
        repeat (400) @(negedge i_clk_sys);
        reg_check(8'h22, 8'((2 * 46) / (2 * HT)));
        valid_en = 1'b0;
        wait_flag(1'b1, 1'b1, 400);
        `CHK(o_synced, 1'b0)
        check_period(2 * DEF_HALF, HT);
        valid_en = 1'b1;
        wait_flag(1'b0, 1'b1, 400);
        i_play = 1'b0;
        half_len = 16'd0;
        reg_write(8'h1f, 8'h20);
        i_play = 1'b1;
        wait_flag(1'b1, 1'b1, 1000);
        half_len = 16'd42;
        repeat (300) @(negedge i_clk_sys);
        `CHK({o_open_loop, o_synced}, 2'b10)
        check_period(2 * 8 * HT, HT);
        i_brake = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        quiet(32);
        i_brake = 1'b0;
        i_play = 1'b0;
        wait_flag(1'b1, 1'b0, 20);
        tally_and_finish();
    end
endmodule // lrt_core_bench
